// *** logic/pmc_pkg.sv ***
package pmc_pkg;
  // Register offsets
  localparam logic [7:0] OFS_RX_GAP_ERR  = 8'hDE;
  localparam logic [7:0] OFS_TX_GAP      = 8'hE0;
  localparam logic [7:0] OFS_LOOPBACK    = 8'hE3;
  localparam logic [7:0] OFS_CRC_EN      = 8'hE4;
  localparam logic [7:0] OFS_RX_GAP_THR  = 8'hE5;
  localparam logic [7:0] OFS_MAX_LEN     = 8'hE6;
  localparam logic [7:0] OFS_MIN_LEN     = 8'hE7;
  localparam logic [7:0] OFS_LO_FRAMES   = 8'hE8;
  localparam logic [7:0] OFS_HI_FRAMES   = 8'hE9;
  localparam logic [7:0] OFS_LO_HALFWD   = 8'hEA;
  localparam logic [7:0] OFS_HI_HALFWD   = 8'hEB;
  localparam logic [7:0] OFS_LEN_ERR     = 8'hEC;

  // Field widths
  localparam int TX_GAP_W  = 8;
  localparam int RX_THR_W  = 6;
  localparam int LEN_W     = 16;
  localparam int FRM_CNT_W = 9;
  localparam int HW_CNT_W  = 14;
  localparam int CNT_W     = 32;
  localparam int GAP_CNT_W = 12;

  // Reset values
  localparam logic [TX_GAP_W-1:0] RST_TX_GAP  = 8'h0B;
  localparam logic [RX_THR_W-1:0] RST_RX_THR  = 6'h0A;
  localparam logic [LEN_W-1:0]    RST_MAX_LEN = 16'h0618;
  localparam logic [LEN_W-1:0]    RST_MIN_LEN = 16'h0040;
  localparam logic                RST_LOOP    = 1'h0;
  localparam logic                RST_CRC_EN  = 1'h1;

  // Timing
  localparam int SYS_CLK_HZ      = 10_000_000;
  localparam int LINE_BPS        = 10_000_000;
  localparam int CYCLES_PER_BIT  = (SYS_CLK_HZ + LINE_BPS - 1) / LINE_BPS;
  localparam int BITS_PER_OCTET  = 8;
  localparam int CYC_PER_OCTET   = CYCLES_PER_BIT * BITS_PER_OCTET;
  localparam logic [GAP_CNT_W-1:0] GAP_SAT = 12'hFFF;

  typedef enum logic [2:0] {
    PMC_RX_IDLE  = 3'b001,
    PMC_RX_FRAME = 3'b010,
    PMC_RX_DROP  = 3'b100
  } pmc_rx_st_t;

  typedef enum logic [2:0] {
    PMC_TX_IDLE = 3'b001,
    PMC_TX_BUSY = 3'b010,
    PMC_TX_GAP  = 3'b100
  } pmc_tx_st_t;

  typedef struct packed {
    logic             sof;
    logic             eof;
    logic [LEN_W-1:0] len;
    logic             crc_bad;
  } pmc_rx_evt_t;

  typedef struct packed {
    logic [FRM_CNT_W-1:0] lo_frames;
    logic [FRM_CNT_W-1:0] hi_frames;
    logic [HW_CNT_W-1:0]  lo_halfwords;
    logic [HW_CNT_W-1:0]  hi_halfwords;
  } pmc_queue_t;
endpackage

// *** logic/pmc_port2_mac_cfg.sv ***
`timescale 1ns/1ns
// Contract
// - 32-bit read-only gap error frame counter
// - Transmit gap is (setting+1) times eight bits
// - Loopback bit, 0 normal, 1 loop
// - Receive CRC check enable, resets enabled
// - Drop frames with gap not above threshold
// - Gap threshold up to 63, resets ten
// - Maximum receive length field, resets 1560
// - Minimum receive length field, resets 64
// - Report low queue frame count, 9 bits
// - Report high queue frame count, 9 bits
// - Frame available flag for host polling
// - Report low queue halfword count, 14 bits
// - Report high queue halfword count, 14 bits
// - Count frames outside length bounds
module pmc_port2_mac_cfg (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                srst,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [31:0]              reg_rdata,
  // Receive frame events from MAC core
  input  wire pmc_pkg::pmc_rx_evt_t rx_evt,
  output logic                     rx_frame_ok,
  output logic                     rx_frame_drop,
  output logic                     rx_gap_error_flag,
  // Transmit frame events
  input  wire logic                tx_sof,
  input  wire logic                tx_eof,
  output logic                     tx_gap_open,
  // Queue status from receive FIFOs
  input  wire pmc_pkg::pmc_queue_t queue_in,
  output logic                     rx_frame_available,
  // Configuration toward MII and PHY
  output logic                     mac_loopback_enable,
  output logic                     rx_checksum_enable
);

  typedef struct packed {
    logic [pmc_pkg::CNT_W-1:0]     gap_err_cnt;
    logic [pmc_pkg::CNT_W-1:0]     len_err_cnt;
    logic [pmc_pkg::TX_GAP_W-1:0]  tx_gap;
    logic                          loopback;
    logic                          crc_en;
    logic [pmc_pkg::RX_THR_W-1:0]  rx_thr;
    logic [pmc_pkg::LEN_W-1:0]     max_len;
    logic [pmc_pkg::LEN_W-1:0]     min_len;
    pmc_pkg::pmc_queue_t           queue;
    pmc_pkg::pmc_rx_st_t           rx_st;
    pmc_pkg::pmc_tx_st_t           tx_st;
    logic [pmc_pkg::GAP_CNT_W-1:0] rx_gap_cnt;
    logic [pmc_pkg::GAP_CNT_W-1:0] tx_gap_cnt;
    logic                          ok;
    logic                          drop;
    logic                          gap_err;
    logic [31:0]                   rdata;
  } pmc_state_t;

  pmc_state_t st_r;
  pmc_state_t st_nxt;

  logic [pmc_pkg::GAP_CNT_W-1:0] rx_gap_need;
  logic [pmc_pkg::GAP_CNT_W-1:0] tx_gap_need;
  logic                          len_bad;
  logic [31:0]                   rd_mux;

  // Gap thresholds in bit times
  always_comb begin
    rx_gap_need = pmc_pkg::GAP_CNT_W'(st_r.rx_thr * pmc_pkg::CYC_PER_OCTET);
    tx_gap_need = pmc_pkg::GAP_CNT_W'((st_r.tx_gap + 9'h001) * pmc_pkg::CYC_PER_OCTET);
    len_bad = (rx_evt.len > st_r.max_len) || (rx_evt.len < st_r.min_len);
  end

  // Read multiplexer
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      pmc_pkg::OFS_RX_GAP_ERR: rd_mux = st_r.gap_err_cnt;
      pmc_pkg::OFS_TX_GAP:     rd_mux[pmc_pkg::TX_GAP_W-1:0] = st_r.tx_gap;
      pmc_pkg::OFS_LOOPBACK:   rd_mux[0] = st_r.loopback;
      pmc_pkg::OFS_CRC_EN:     rd_mux[0] = st_r.crc_en;
      pmc_pkg::OFS_RX_GAP_THR: rd_mux[pmc_pkg::RX_THR_W-1:0] = st_r.rx_thr;
      pmc_pkg::OFS_MAX_LEN:    rd_mux[pmc_pkg::LEN_W-1:0] = st_r.max_len;
      pmc_pkg::OFS_MIN_LEN:    rd_mux[pmc_pkg::LEN_W-1:0] = st_r.min_len;
      pmc_pkg::OFS_LO_FRAMES:  rd_mux[pmc_pkg::FRM_CNT_W-1:0] = st_r.queue.lo_frames;
      pmc_pkg::OFS_HI_FRAMES:  rd_mux[pmc_pkg::FRM_CNT_W-1:0] = st_r.queue.hi_frames;
      pmc_pkg::OFS_LO_HALFWD:  rd_mux[pmc_pkg::HW_CNT_W-1:0] = st_r.queue.lo_halfwords;
      pmc_pkg::OFS_HI_HALFWD:  rd_mux[pmc_pkg::HW_CNT_W-1:0] = st_r.queue.hi_halfwords;
      pmc_pkg::OFS_LEN_ERR:    rd_mux = st_r.len_err_cnt;
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.ok = 1'b0;
    st_nxt.drop = 1'b0;
    st_nxt.gap_err = 1'b0;
    st_nxt.queue = queue_in;
    st_nxt.rdata = reg_rd ? rd_mux : 32'h0000_0000;

    // Register writes, only defined field bits kept
    if (reg_wr) begin
      case (reg_addr)
        pmc_pkg::OFS_TX_GAP:     st_nxt.tx_gap = reg_wdata[pmc_pkg::TX_GAP_W-1:0];
        pmc_pkg::OFS_LOOPBACK:   st_nxt.loopback = reg_wdata[0];
        pmc_pkg::OFS_CRC_EN:     st_nxt.crc_en = reg_wdata[0];
        pmc_pkg::OFS_RX_GAP_THR: st_nxt.rx_thr = reg_wdata[pmc_pkg::RX_THR_W-1:0];
        pmc_pkg::OFS_MAX_LEN:    st_nxt.max_len = reg_wdata[pmc_pkg::LEN_W-1:0];
        pmc_pkg::OFS_MIN_LEN:    st_nxt.min_len = reg_wdata[pmc_pkg::LEN_W-1:0];
        default: begin
        end
      endcase
    end

    // Receive gap timer, saturating
    if (st_r.rx_gap_cnt != pmc_pkg::GAP_SAT) begin
      st_nxt.rx_gap_cnt = st_r.rx_gap_cnt + 12'h001;
    end

    // Receive frame checker
    case (st_r.rx_st)
      pmc_pkg::PMC_RX_IDLE: begin
        if (rx_evt.sof) begin
          if (st_r.rx_gap_cnt <= rx_gap_need) begin
            st_nxt.rx_st = pmc_pkg::PMC_RX_DROP;
            st_nxt.gap_err = 1'b1;
            st_nxt.gap_err_cnt = st_r.gap_err_cnt + 32'h0000_0001;
          end else begin
            st_nxt.rx_st = pmc_pkg::PMC_RX_FRAME;
          end
        end
      end
      pmc_pkg::PMC_RX_FRAME: begin
        if (rx_evt.eof) begin
          st_nxt.rx_st = pmc_pkg::PMC_RX_IDLE;
          st_nxt.rx_gap_cnt = '0;
          if (len_bad) begin
            st_nxt.drop = 1'b1;
            st_nxt.len_err_cnt = st_r.len_err_cnt + 32'h0000_0001;
          end else if (st_r.crc_en && rx_evt.crc_bad) begin
            st_nxt.drop = 1'b1;
          end else begin
            st_nxt.ok = 1'b1;
          end
        end
      end
      pmc_pkg::PMC_RX_DROP: begin
        if (rx_evt.eof) begin
          st_nxt.rx_st = pmc_pkg::PMC_RX_IDLE;
          st_nxt.rx_gap_cnt = '0;
          st_nxt.drop = 1'b1;
        end
      end
      default: begin
        st_nxt.rx_st = pmc_pkg::PMC_RX_IDLE;
      end
    endcase

    // Transmit gap sequencer
    case (st_r.tx_st)
      pmc_pkg::PMC_TX_IDLE: begin
        if (tx_sof) begin
          st_nxt.tx_st = pmc_pkg::PMC_TX_BUSY;
        end
      end
      pmc_pkg::PMC_TX_BUSY: begin
        if (tx_eof) begin
          st_nxt.tx_st = pmc_pkg::PMC_TX_GAP;
          st_nxt.tx_gap_cnt = 12'h001;
        end
      end
      pmc_pkg::PMC_TX_GAP: begin
        if (st_r.tx_gap_cnt >= tx_gap_need) begin
          st_nxt.tx_st = pmc_pkg::PMC_TX_IDLE;
        end else begin
          st_nxt.tx_gap_cnt = st_r.tx_gap_cnt + 12'h001;
        end
      end
      default: begin
        st_nxt.tx_st = pmc_pkg::PMC_TX_IDLE;
      end
    endcase

    if (srst) begin
      st_nxt = '0;
      st_nxt.tx_gap = pmc_pkg::RST_TX_GAP;
      st_nxt.loopback = pmc_pkg::RST_LOOP;
      st_nxt.crc_en = pmc_pkg::RST_CRC_EN;
      st_nxt.rx_thr = pmc_pkg::RST_RX_THR;
      st_nxt.max_len = pmc_pkg::RST_MAX_LEN;
      st_nxt.min_len = pmc_pkg::RST_MIN_LEN;
      st_nxt.rx_st = pmc_pkg::PMC_RX_IDLE;
      st_nxt.tx_st = pmc_pkg::PMC_TX_IDLE;
      st_nxt.rx_gap_cnt = pmc_pkg::GAP_SAT;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_r <= st_nxt;
  end

  // Outputs
  assign reg_rdata           = st_r.rdata;
  assign rx_frame_ok         = st_r.ok;
  assign rx_frame_drop       = st_r.drop;
  assign rx_gap_error_flag   = st_r.gap_err;
  assign tx_gap_open         = (st_r.tx_st == pmc_pkg::PMC_TX_IDLE);
  assign rx_frame_available  = (st_r.queue.lo_frames != '0) || (st_r.queue.hi_frames != '0);
  assign mac_loopback_enable = st_r.loopback;
  assign rx_checksum_enable  = st_r.crc_en;

endmodule

// *** sim/pmc_cfg_sva.sv ***
`timescale 1ns/1ns
module pmc_cfg_sva (
  // Register port
  input wire logic                 sys_clk,
  input wire logic                 srst,
  input wire logic [7:0]           reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [31:0]          reg_rdata,
  // Frame side
  input wire pmc_pkg::pmc_rx_evt_t rx_evt,
  input wire logic                 rx_frame_ok,
  input wire logic                 rx_frame_drop,
  input wire logic                 rx_gap_error_flag,
  input wire logic                 tx_sof,
  input wire logic                 tx_eof,
  input wire logic                 tx_gap_open,
  input wire pmc_pkg::pmc_queue_t  queue_in,
  input wire logic                 rx_frame_available,
  input wire logic                 mac_loopback_enable,
  input wire logic                 rx_checksum_enable
);
  logic [7:0]  gap_r;
  logic [11:0] cnt_r;
  // Shadow of the transmit gap and cycles since frame end
  always_ff @(posedge sys_clk) begin
    if (srst) gap_r <= 8'h0B;
    else if (reg_wr && reg_addr == pmc_pkg::OFS_TX_GAP) gap_r <= reg_wdata[7:0];
    cnt_r <= tx_eof ? 12'h001 : cnt_r + 12'h001;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  chk_rdata_idle: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside read slot");
  chk_loop_wr: assert property (reg_wr && reg_addr == pmc_pkg::OFS_LOOPBACK |=>
    mac_loopback_enable == $past(reg_wdata[0])) else $error("loopback output wrong");
  chk_crc_wr: assert property (reg_wr && reg_addr == pmc_pkg::OFS_CRC_EN |=>
    rx_checksum_enable == $past(reg_wdata[0])) else $error("checksum enable wrong");
  chk_flag_cause: assert property (rx_gap_error_flag |-> $past(rx_evt.sof))
    else $error("gap flag without frame start");
  chk_ok_cause: assert property (rx_frame_ok || rx_frame_drop |->
    $past(rx_evt.eof) && !(rx_frame_ok && rx_frame_drop)) else $error("bad frame verdict");
  chk_tx_close: assert property (tx_sof && tx_gap_open |=> !tx_gap_open)
    else $error("transmit did not close");
  chk_tx_reopen: assert property ($rose(tx_gap_open) |->
    cnt_r == (gap_r + 12'h001) * 12'h008 + 12'h001) else $error("transmit gap length wrong");
  chk_avail_level: assert property (queue_in == $past(queue_in) &&
    $past(queue_in) == $past(queue_in, 2) |-> rx_frame_available ==
    (queue_in.lo_frames != 9'h0 || queue_in.hi_frames != 9'h0)) else $error("available wrong");
endmodule

// *** sim/pmc_core_model.sv ***
`timescale 1ns/1ns
module pmc_core_model (
  // Clock
  input wire logic            sys_clk,
  // Toward the block
  output pmc_pkg::pmc_rx_evt_t rx_evt,
  output pmc_pkg::pmc_queue_t  queue_in
);
  initial begin
    rx_evt = '0;
    queue_in = '0;
  end
  // Frame after gap idle cycles
  task automatic send(input int gap, input logic [15:0] len, input logic bad);
    repeat (gap) @(posedge sys_clk);
    rx_evt.sof <= 1'h1;
    @(posedge sys_clk);
    rx_evt.sof <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rx_evt.eof <= 1'h1;
    rx_evt.len <= len;
    rx_evt.crc_bad <= bad;
    @(posedge sys_clk);
    rx_evt.eof <= 1'h0;
    rx_evt.len <= ~len;
    rx_evt.crc_bad <= ~bad;
  endtask
  // Queue counts, read back; the frame counts also drive the frame available flag
  task automatic set_queue(input pmc_pkg::pmc_queue_t q);
    @(posedge sys_clk);
    queue_in <= q;
  endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] e;
  } pmc_row_t;
  logic        sys_clk, srst, reg_wr, reg_rd, tx_sof, tx_eof, rx_frame_ok, rx_frame_drop;
  logic        rx_gap_error_flag, tx_gap_open, rx_frame_available, mac_loopback_enable;
  logic        rx_checksum_enable;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  pmc_pkg::pmc_rx_evt_t rx_evt;
  pmc_pkg::pmc_queue_t  queue_in;
  pmc_row_t    rows [19];
  int          mismatches, checks_done, n_ok, n_drop, n_flag, n;
  pmc_port2_mac_cfg uut (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_evt, .rx_frame_ok, .rx_frame_drop, .rx_gap_error_flag, .tx_sof, .tx_eof, .tx_gap_open,
    .queue_in, .rx_frame_available, .mac_loopback_enable, .rx_checksum_enable);
  pmc_core_model core (.sys_clk, .rx_evt, .queue_in);
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    n_ok += (rx_frame_ok === 1'h1);
    n_drop += (rx_frame_drop === 1'h1);
    n_flag += (rx_gap_error_flag === 1'h1);
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #3000000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    {srst, reg_wr, reg_rd, tx_sof, tx_eof} = 5'h10;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    rows = '{'{8'hDE, 32'h0}, '{8'hE0, 32'h0B}, '{8'hE3, 32'h0},
      '{8'hE4, 32'h1}, '{8'hE5, 32'h0A}, '{8'hE6, 32'h618},
      '{8'hE7, 32'h40}, '{8'hDE, 32'h0}, '{8'hE0, 32'hFF}, '{8'hE3, 32'h1},
      '{8'hE4, 32'h1}, '{8'hE5, 32'h3F}, '{8'hE6, 32'hFFFF}, '{8'hE7, 32'hFFFF},
      '{8'hE8, 32'h1FF}, '{8'hE9, 32'h0AA}, '{8'hEA, 32'h3FFF},
      '{8'hEB, 32'h1555}, '{8'hE1, 32'h0}};
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    core.set_queue('{9'h1FF, 9'h0AA, 14'h3FFF, 14'h1555});
    foreach (rows[i]) begin
      if (i > 6) wr(rows[i].a, 32'hFFFFFFFF);
      rd(rows[i].a, v);
      cmp($sformatf("reg %h", rows[i].a), rows[i].e, v);
    end
    cmp("loopback", 32'h1, {31'h0, mac_loopback_enable});
    cmp("available", 32'h1, {31'h0, rx_frame_available});
    $display("test registers done");
    wr(pmc_pkg::OFS_RX_GAP_THR, 32'h2);
    wr(pmc_pkg::OFS_MAX_LEN, 32'h618);
    wr(pmc_pkg::OFS_MIN_LEN, 32'h40);
    wr(pmc_pkg::OFS_CRC_EN, 32'h0);
    core.send(20, 16'h0064, 1'h0);
    core.send(5, 16'h0064, 1'h0);
    core.send(40, 16'h0010, 1'h0);
    core.send(40, 16'h0700, 1'h0);
    core.send(40, 16'h0064, 1'h1);
    wr(pmc_pkg::OFS_CRC_EN, 32'h1);
    core.send(40, 16'h0064, 1'h1);
    repeat (3) @(posedge sys_clk);
    cmp("accepted", 32'h2, n_ok);
    cmp("dropped", 32'h4, n_drop);
    cmp("gap flags", 32'h1, n_flag);
    rd(pmc_pkg::OFS_RX_GAP_ERR, v);
    cmp("gap errors", 32'h1, v);
    rd(pmc_pkg::OFS_LEN_ERR, v);
    cmp("length errors", 32'h2, v);
    $display("test receive done");
    @(posedge sys_clk);
    tx_sof <= 1'h1;
    @(posedge sys_clk);
    tx_sof <= 1'h0;
    repeat (4) @(posedge sys_clk);
    tx_eof <= 1'h1;
    @(posedge sys_clk);
    tx_eof <= 1'h0;
    #1 n = 0;
    while (tx_gap_open !== 1'h1 && n < 2100) begin
      @(posedge sys_clk);
      #1 n++;
    end
    cmp("tx gap", 32'h100 * 32'h8, n);
    $display("test transmit done");
    core.set_queue('0);
    repeat (3) @(posedge sys_clk);
    cmp("available", 32'h0, {31'h0, rx_frame_available});
    srst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    rd(pmc_pkg::OFS_TX_GAP, v);
    cmp("tx gap reset", 32'h0B, v);
    rd(pmc_pkg::OFS_RX_GAP_ERR, v);
    cmp("gap errors reset", 32'h0, v);
    cmp("checksum enable", 32'h1, {31'h0, rx_checksum_enable});
    cmp("loopback reset", 32'h0, {31'h0, mac_loopback_enable});
    $display("test reset done");
    tally_and_finish;
  end
endmodule
bind pmc_port2_mac_cfg pmc_cfg_sva chk (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .rx_evt, .rx_frame_ok, .rx_frame_drop, .rx_gap_error_flag, .tx_sof, .tx_eof,
  .tx_gap_open, .queue_in, .rx_frame_available, .mac_loopback_enable, .rx_checksum_enable);
